// *** src/lgpsd_pkg.sv ***
package lgpsd_pkg;
   // ****************************************
   // Channel and word sizes
   // ****************************************
   localparam int NCH    = 24;
   localparam int GS_W   = 16;
   localparam int DC_W   = 7;
   localparam int GB_W   = 8;
   localparam int GS_LEN = NCH * GS_W;
   localparam int DG_LEN = NCH * DC_W + GB_W;
   localparam int SR_W   = GS_LEN;
   localparam logic [15:0] CNT_FULL = 16'hFFFF;
   localparam logic [15:0] CNT_LAST = 16'hFFFE;

   // ****************************************
   // Positions of the synchronised pin vector
   // ****************************************
   localparam int P_SCK  = 0;
   localparam int P_DIN  = 1;
   localparam int P_PH   = 2;
   localparam int P_DLY  = 3;
   localparam int P_LAT  = 4;
   localparam int P_PCK  = 5;
   localparam int P_LOAD_MODE_SELECT = 6;
   localparam int P_BLK  = 7;
   localparam int P_WAVE = 8;
   localparam int P_ONE  = 9;
   localparam int P_HOT  = 10;
   localparam int P_OPEN = 11;
   localparam int P_W    = P_OPEN + NCH;

   // ****************************************
   // Register map and fields
   // ****************************************
   localparam int          A_W       = 5;
   localparam logic [4:0]  A_CTRL    = 5'h00;
   localparam logic [4:0]  A_STAT    = 5'h04;
   localparam logic [4:0]  A_IEN     = 5'h08;
   localparam logic [4:0]  A_ICLR    = 5'h0C;
   localparam logic [4:0]  A_STATE   = 5'h10;
   localparam int          ST_OPEN   = 0;
   localparam int          ST_HOT    = 1;
   localparam int          ST_LATCH  = 2;
   localparam int          ST_W      = 3;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;
   localparam logic [31:0] ZERO32    = 32'h0000_0000;

   // Mapped word addresses
   function automatic logic lgpsd_addr_ok(input logic [4:0] a);
      return (a == A_CTRL) || (a == A_STAT) || (a == A_IEN) || (a == A_ICLR) ||
             (a == A_STATE);
   endfunction : lgpsd_addr_ok

   // Bit reversal spreads the on time over the whole period
   function automatic logic [15:0] lgpsd_rev16(input logic [15:0] v);
      for (int i = 0; i < 16; i++) begin
         lgpsd_rev16[i] = v[15-i];
      end
   endfunction : lgpsd_rev16
endpackage : lgpsd_pkg

// *** src/lgpsd_pin_if.sv ***
`timescale 1ns/1ps
interface lgpsd_pin_if #(parameter int W = 1);
   logic [W-1:0] lvl;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   modport src (output lvl, output rise, output fall);
   modport dst (input lvl, input rise, input fall);
endinterface : lgpsd_pin_if

// *** src/lgpsd_sync.sv ***
`timescale 1ns/1ps
module lgpsd_sync import lgpsd_pkg::*; #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Raw pins
   input  wire logic [W-1:0] d,
   // Synchronised levels and edges
   lgpsd_pin_if.src          p
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] prev;
   } lgpsd_sync_t;

   lgpsd_sync_t s_r;
   lgpsd_sync_t s_nxt;

   // ****************************************
   // Two-stage synchroniser and edge finder
   // ****************************************
   always_comb begin
      s_nxt      = s_r;
      s_nxt.s1   = d;
      s_nxt.s2   = s_r.s1;
      s_nxt.prev = s_r.s2;
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Edges look only at the second stage and later
   assign p.lvl  = s_r.s2;
   assign p.rise = s_r.s2 & ~s_r.prev;
   assign p.fall = ~s_r.s2 & s_r.prev;
endmodule : lgpsd_sync

// *** src/lgpsd_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Shift data on shift clock rise when phase select low, fall when high.
// R2 - Output delay select high moves serial out change by half a shift cycle.
// R3 - One serial input carries both word kinds; serial out feeds next device.
// R4 - Shift clock and PWM clock are repeated inverted to the next device.
// R5 - Latch open on strobe xor phase; counter forced to all ones meanwhile.
// R6 - With strobe at its inactive level the latches hold their contents.
// R7 - PWM counter steps on count clock rise, or fall with phase select high.
// R8 - Blanking forces every channel off; otherwise channels follow PWM.
// R9 - Mode select high loads correction and brightness; low loads grayscale.
// R10 - Alarm pulls low on open LED unblanked, on overheating when blanked.
// R11 - Waveform select high gives single pulse, low gives spread pulses.
// R12 - Single pass select high stops the counter after one full period.
// R13 - Each of 24 channels keeps a 16-bit grayscale value.
// R14 - Each channel keeps a 7-bit current correction value.
// R15 - One 8-bit global brightness value scales all currents.
// R16 - Open LED flags are placed into the chain for shifting out.
// R17 - A channel is on while counter is below its grayscale value.
// R18 - Words go most significant bit first; chain length follows load mode.
module lgpsd_top import lgpsd_pkg::*; (
   // Clock and reset
   input  wire logic                  CLK,
   input  wire logic                  RST_N,
   // Serial link pins
   input  wire logic                  SHIFT_CLOCK,
   input  wire logic                  SERIAL_IN,
   input  wire logic                  LATCH_STROBE,
   input  wire logic                  PWM_COUNT_CLOCK,
   output wire logic                  SERIAL_OUT,
   output wire logic                  SHIFT_CLOCK_REPEAT,
   output wire logic                  LATCH_STROBE_REPEAT,
   output wire logic                  PWM_CLOCK_REPEAT,
   // Mode pins
   input  wire logic                  EDGE_PHASE_SELECT,
   input  wire logic                  OUTPUT_DELAY_SELECT,
   input  wire logic                  LOAD_MODE_SELECT,
   input  wire logic                  BLANK_ALL,
   input  wire logic                  WAVEFORM_STYLE_SELECT,
   input  wire logic                  SINGLE_PASS_SELECT,
   // Fault sensing
   input  wire logic [NCH-1:0]        OPEN_LED_DETECT,
   input  wire logic                  OVER_TEMP,
   output wire logic                  ALARM_OUT,
   output wire logic                  ALARM_OE,
   // Channel and current control
   output wire logic [NCH-1:0]        CHANNEL_SINK_OUTPUTS,
   output wire logic [NCH*DC_W-1:0]   CURRENT_CORRECTION,
   output wire logic [GB_W-1:0]       GLOBAL_BRIGHTNESS,
   // AXI4-Lite slave
   input  wire logic                  AWVALID,
   output wire logic                  AWREADY,
   input  wire logic [A_W-1:0]        AWADDR,
   input  wire logic                  WVALID,
   output wire logic                  WREADY,
   input  wire logic [31:0]           WDATA,
   input  wire logic [3:0]            WSTRB,
   output wire logic                  BVALID,
   input  wire logic                  BREADY,
   output wire logic [1:0]            BRESP,
   input  wire logic                  ARVALID,
   output wire logic                  ARREADY,
   input  wire logic [A_W-1:0]        ARADDR,
   output wire logic                  RVALID,
   input  wire logic                  RREADY,
   output wire logic [31:0]           RDATA,
   output wire logic [1:0]            RRESP,
   // Interrupt
   output wire logic                  IRQ
);
   typedef struct packed {
      logic [SR_W-1:0]                sr;
      logic [NCH-1:0][GS_W-1:0]       gs;
      logic [NCH-1:0][DC_W-1:0]       dc;
      logic [GB_W-1:0]                gb;
      logic [15:0]                    cnt;
      logic                           done;
      logic                           lat_prev;
      logic                           sout;
      logic [NCH-1:0]                 chan;
      logic                           alarm_oe;
      logic                           sck_rep;
      logic                           lat_rep;
      logic                           pck_rep;
      logic                           aw_have;
      logic                           w_have;
      logic [A_W-1:0]                 awaddr;
      logic [31:0]                    wdata;
      logic                           wlane0;
      logic                           awready;
      logic                           wready;
      logic                           bvalid;
      logic [1:0]                     bresp;
      logic                           arready;
      logic                           rvalid;
      logic [31:0]                    rdata;
      logic [1:0]                     rresp;
      logic                           sw_blank;
      logic [ST_W-1:0]                stat;
      logic [ST_W-1:0]                ien;
      logic                           irq;
   } lgpsd_state_t;

   lgpsd_state_t s_r;
   lgpsd_state_t s_nxt;

   // ****************************************
   // Pin synchronisation
   // ****************************************
   lgpsd_pin_if #(.W(P_W)) pin ();
   logic [P_W-1:0] raw;

   assign raw = {OPEN_LED_DETECT, OVER_TEMP, SINGLE_PASS_SELECT, WAVEFORM_STYLE_SELECT,
                 BLANK_ALL, LOAD_MODE_SELECT, PWM_COUNT_CLOCK, LATCH_STROBE,
                 OUTPUT_DELAY_SELECT, EDGE_PHASE_SELECT, SERIAL_IN, SHIFT_CLOCK};

   lgpsd_sync #(.W(P_W)) u_sync (
      .clk   (CLK),
      .rst_n (RST_N),
      .d     (raw),
      .p     (pin)
   );

   // ****************************************
   // Decoded link events
   // ****************************************
   logic           phase;
   logic           sck_edge;
   logic           sck_back;
   logic           pck_edge;
   logic           lat_open;
   logic           blank;
   logic           load_mode_select;
   logic [NCH-1:0] open_led;

   assign phase    = pin.lvl[P_PH];
   assign sck_edge = phase ? pin.fall[P_SCK] : pin.rise[P_SCK];  // R1
   assign sck_back = phase ? pin.rise[P_SCK] : pin.fall[P_SCK];
   assign pck_edge = phase ? pin.fall[P_PCK] : pin.rise[P_PCK];  // R7
   assign lat_open = pin.lvl[P_LAT] ^ phase;                       // R5
   assign blank    = pin.lvl[P_BLK] | s_r.sw_blank;
   assign load_mode_select     = pin.lvl[P_LOAD_MODE_SELECT];
   assign open_led = pin.lvl[P_OPEN +: NCH];

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      logic [ST_W-1:0] clr;
      logic [ST_W-1:0] ev;
      logic [15:0]     cmp;
      clr   = '0;
      ev    = '0;
      cmp   = '0;
      s_nxt = s_r;

      // Serial chain, most significant bit first
      if (sck_edge) begin
         s_nxt.sr = {s_r.sr[SR_W-2:0], pin.lvl[P_DIN]};  // R1 R3 R18
         if (!pin.lvl[P_DLY]) begin
            s_nxt.sout = load_mode_select ? s_r.sr[DG_LEN-2] : s_r.sr[GS_LEN-2];  // R2 R18
         end
      end
      if (sck_back && pin.lvl[P_DLY]) begin
         s_nxt.sout = load_mode_select ? s_r.sr[DG_LEN-1] : s_r.sr[GS_LEN-1];  // R2
      end

      // Latch closing places open LED flags at the head of the chain
      s_nxt.lat_prev = lat_open;
      if (s_r.lat_prev && !lat_open) begin
         ev[ST_LATCH] = 1'b1;
         if (load_mode_select) begin
            s_nxt.sr[DG_LEN-1 -: NCH] = open_led;  // R16
         end else begin
            s_nxt.sr[GS_LEN-1 -: NCH] = open_led;  // R16
         end
      end

      // Transparent latches, held while the strobe is inactive, and PWM counter, which counts only then
      if (lat_open) begin  // R6
         s_nxt.cnt  = CNT_FULL;  // R5
         s_nxt.done = 1'b0;
         if (load_mode_select) begin
            s_nxt.gb = s_r.sr[DG_LEN-1 -: GB_W];  // R9 R15
            for (int i = 0; i < NCH; i++) begin
               s_nxt.dc[i] = s_r.sr[DC_W*i +: DC_W];  // R9 R14
            end
         end else begin
            for (int i = 0; i < NCH; i++) begin
               s_nxt.gs[i] = s_r.sr[GS_W*i +: GS_W];  // R9 R13
            end
         end
      end else if (pck_edge && !(pin.lvl[P_ONE] && s_r.done)) begin
         s_nxt.cnt  = 16'(s_r.cnt + 16'h0001);  // R7 R12
         // Done marks only the rest at all ones, so free running clears it again
         s_nxt.done = (s_r.cnt == CNT_LAST);
      end

      // Channel compare
      cmp = pin.lvl[P_WAVE] ? s_r.cnt : lgpsd_rev16(s_r.cnt);  // R11
      for (int i = 0; i < NCH; i++) begin
         s_nxt.chan[i] = !blank && (cmp < s_r.gs[i]);  // R8 R17
      end

      // Alarm and repeated clocks
      s_nxt.alarm_oe = blank ? pin.lvl[P_HOT] : |open_led;  // R10
      s_nxt.sck_rep  = ~pin.lvl[P_SCK];                     // R4
      s_nxt.pck_rep  = ~pin.lvl[P_PCK];                     // R4
      s_nxt.lat_rep  = pin.lvl[P_LAT];

      // Write channel
      if (s_r.bvalid && BREADY) begin
         s_nxt.bvalid = 1'b0;
      end
      if (AWVALID && s_r.awready) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.awaddr  = AWADDR;
      end
      if (WVALID && s_r.wready) begin
         s_nxt.w_have = 1'b1;
         s_nxt.wdata  = WDATA;
         s_nxt.wlane0 = WSTRB[0];
      end
      if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = lgpsd_addr_ok(s_r.awaddr) ? RESP_OK : RESP_ERR;
         if (s_r.wlane0) begin
            case (s_r.awaddr)
               A_CTRL: begin
                  s_nxt.sw_blank = s_r.wdata[0];
               end
               A_IEN: begin
                  s_nxt.ien = s_r.wdata[ST_W-1:0];
               end
               A_ICLR: begin
                  clr = s_r.wdata[ST_W-1:0];
               end
               default: begin
               end
            endcase
         end
      end
      s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
      s_nxt.wready  = !s_nxt.w_have && !s_nxt.bvalid;

      // Read channel
      if (s_r.rvalid && RREADY) begin
         s_nxt.rvalid = 1'b0;
      end
      if (ARVALID && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = lgpsd_addr_ok(ARADDR) ? RESP_OK : RESP_ERR;
         case (ARADDR)
            A_CTRL:  s_nxt.rdata = {31'h0000_0000, s_r.sw_blank};
            A_STAT:  s_nxt.rdata = {29'h0000_0000, s_r.stat};
            A_IEN:   s_nxt.rdata = {29'h0000_0000, s_r.ien};
            A_STATE: s_nxt.rdata = {s_r.cnt, 12'h000, s_r.done, load_mode_select, lat_open, blank};
            default: s_nxt.rdata = ZERO32;
         endcase
      end
      s_nxt.arready = !s_nxt.rvalid;

      // Sticky status, a new event beats a clear
      ev[ST_OPEN] = |pin.rise[P_OPEN +: NCH];
      ev[ST_HOT]  = pin.rise[P_HOT];
      s_nxt.stat  = (s_r.stat & ~clr) | ev;
      s_nxt.irq   = |(s_nxt.stat & s_nxt.ien);
   end

   // State register
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign SERIAL_OUT           = s_r.sout;
   assign SHIFT_CLOCK_REPEAT   = s_r.sck_rep;
   assign LATCH_STROBE_REPEAT  = s_r.lat_rep;
   assign PWM_CLOCK_REPEAT     = s_r.pck_rep;
   assign ALARM_OUT            = 1'b0;
   assign ALARM_OE             = s_r.alarm_oe;
   assign CHANNEL_SINK_OUTPUTS = s_r.chan;
   assign CURRENT_CORRECTION   = s_r.dc;
   assign GLOBAL_BRIGHTNESS    = s_r.gb;
   assign AWREADY              = s_r.awready;
   assign WREADY               = s_r.wready;
   assign BVALID               = s_r.bvalid;
   assign BRESP                = s_r.bresp;
   assign ARREADY              = s_r.arready;
   assign RVALID               = s_r.rvalid;
   assign RDATA                = s_r.rdata;
   assign RRESP                = s_r.rresp;
   assign IRQ                  = s_r.irq;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   property p_shift_in;
      sck_edge |=> s_r.sr[0] == $past(pin.lvl[P_DIN]);
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("shift bit lost");  // R1

   property p_sout_fast;
      sck_edge && !pin.lvl[P_DLY] |=>
         SERIAL_OUT == ($past(load_mode_select) ? s_r.sr[DG_LEN-1] : s_r.sr[GS_LEN-1]);
   endproperty
   a_sout_fast: assert property (p_sout_fast) else $error("serial out wrong");  // R2

   property p_clk_rep;
      RST_N |=> SHIFT_CLOCK_REPEAT == !$past(pin.lvl[P_SCK]) &&
          PWM_CLOCK_REPEAT == !$past(pin.lvl[P_PCK]);
   endproperty
   a_clk_rep: assert property (p_clk_rep) else $error("repeat clock wrong");  // R4

   property p_latch_full;
      lat_open |=> s_r.cnt == CNT_FULL ##1 !lat_open || s_r.cnt == CNT_FULL;
   endproperty
   a_latch_full: assert property (p_latch_full) else $error("counter not full");  // R5

   property p_hold;
      !lat_open |=> $stable(s_r.gs) && $stable(s_r.dc) && $stable(s_r.gb);
   endproperty
   a_hold: assert property (p_hold) else $error("latch changed");  // R6

   property p_count;
      pck_edge && !lat_open && !(pin.lvl[P_ONE] && s_r.done) |=>
         s_r.cnt == $past(s_r.cnt) + 16'h0001;
   endproperty
   a_count: assert property (p_count) else $error("counter step wrong");  // R7

   property p_blank;
      blank |=> CHANNEL_SINK_OUTPUTS == '0;
   endproperty
   a_blank: assert property (p_blank) else $error("channel on while blank");  // R8

   property p_alarm;
      blank && pin.lvl[P_HOT] |=> ALARM_OE;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm missing");  // R10

   property p_single;
      pin.lvl[P_ONE] && s_r.done && !lat_open |=> s_r.cnt == CNT_FULL;
   endproperty
   a_single: assert property (p_single) else $error("single pass ran on");  // R12

   property p_chan0;
      !blank && pin.lvl[P_WAVE] && s_r.cnt < s_r.gs[0] |=> CHANNEL_SINK_OUTPUTS[0];
   endproperty
   a_chan0: assert property (p_chan0) else $error("channel 0 off");  // R17

   c_latch: cover property (lat_open ##1 !lat_open);
   c_wrap:  cover property (pck_edge && s_r.cnt == CNT_FULL && !lat_open);
   c_write: cover property (BVALID && BREADY);
   c_irq:   cover property (IRQ);
endmodule : lgpsd_top

// *** sim/lgpsd_ctrl_model.sv ***
`timescale 1ns/1ps
// ********************************
// Display controller on the chain
// ********************************
module lgpsd_ctrl_model (
   // Clock and phase
   input  wire logic clk,
   input  wire logic ph,
   // Link pins
   output wire logic sck,
   output wire logic sdi,
   output wire logic lat,
   output wire logic pck
);
   logic sck_r = 1'h0;
   logic sdi_r = 1'h0;
   logic lat_r = 1'h0;
   logic pck_r = 1'h0;

   // Clock and strobe levels flip with the phase so the active edge and level follow it; data does not
   assign sck = sck_r ^ ph;
   assign lat = lat_r ^ ph;
   assign pck = pck_r ^ ph;
   assign sdi = sdi_r;

   // One bit per link period, data moves with the non-sampling edge
   task automatic send_bit(input logic b);
      sdi_r <= b;
      repeat (4) @(posedge clk);
      sck_r <= 1'h1;
      repeat (4) @(posedge clk);
      sck_r <= 1'h0;
   endtask : send_bit

   // Outside frames the data line shows no stale value
   task automatic end_frame();
      sdi_r <= ~sdi_r;
   endtask : end_frame

   // Strobe held active while the latches should be open
   task automatic strobe(input logic on);
      lat_r <= on;
   endtask : strobe

   // One edge of the count clock, held for half a period
   task automatic count_edge(input logic on);
      pck_r <= on;
      repeat (4) @(posedge clk);
   endtask : count_edge
endmodule : lgpsd_ctrl_model

// *** sim/test_led_grayscale_pwm_serial_driver.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
      end \
   end
module test_led_grayscale_pwm_serial_driver import lgpsd_pkg::*; ();
   logic                clk = 1'h0, rst_n = 1'h0;
   logic                ph = 1'h0, dly = 1'h0, load_mode_select = 1'h0, blank = 1'h0;
   logic                wave = 1'h1, onep = 1'h0, hot = 1'h0;
   logic [NCH-1:0]      open_det = '0;
   logic                awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic                arvalid = 1'h0, rready = 1'h0;
   logic [A_W-1:0]      awaddr = '0, araddr = '0;
   logic [31:0]         wdata = ZERO32;
   logic [3:0]          wstrb = 4'hF;
   logic                sck, sdi, lat, pck, so, sck_rep, lat_rep, pck_rep, alarm, alarm_oe;
   logic                awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]          bresp, rresp, resp;
   logic [31:0]         rdata, q;
   logic [NCH-1:0]      chan;
   logic [NCH*DC_W-1:0] corr;
   logic [GB_W-1:0]     gb;
   logic [SR_W-1:0]     v;
   logic [15:0]         gs [NCH];
   int                  mismatches = 0;
   int                  n_tests = 0;

   // ********************************
   // Clock, partner and device
   // ********************************
   // Free running system clock
   always #12.5 clk = ~clk;

   lgpsd_ctrl_model ctl (.clk(clk), .ph(ph), .sck(sck), .sdi(sdi), .lat(lat), .pck(pck));

   lgpsd_top uut (
      .CLK(clk), .RST_N(rst_n), .SHIFT_CLOCK(sck), .SERIAL_IN(sdi), .LATCH_STROBE(lat),
      .PWM_COUNT_CLOCK(pck), .SERIAL_OUT(so), .SHIFT_CLOCK_REPEAT(sck_rep),
      .LATCH_STROBE_REPEAT(lat_rep), .PWM_CLOCK_REPEAT(pck_rep), .EDGE_PHASE_SELECT(ph),
      .OUTPUT_DELAY_SELECT(dly), .LOAD_MODE_SELECT(load_mode_select), .BLANK_ALL(blank),
      .WAVEFORM_STYLE_SELECT(wave), .SINGLE_PASS_SELECT(onep), .OPEN_LED_DETECT(open_det),
      .OVER_TEMP(hot), .ALARM_OUT(alarm), .ALARM_OE(alarm_oe), .CHANNEL_SINK_OUTPUTS(chan),
      .CURRENT_CORRECTION(corr), .GLOBAL_BRIGHTNESS(gb), .AWVALID(awvalid),
      .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
      .WSTRB(wstrb), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
      .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata),
      .RRESP(rresp), .IRQ(irq)
   );

   // ********************************
   // Helpers
   // ********************************
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask : settle

   // One register access, each channel released when taken
   task automatic bus(input logic wr, input logic [A_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic [1:0] r);
      @(posedge clk);
      awvalid <= wr;
      wvalid  <= wr;
      bready  <= wr;
      awaddr  <= a;
      wdata   <= d;
      arvalid <= !wr;
      rready  <= !wr;
      araddr  <= a;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (arready) arvalid <= 1'h0;
      end while ((wr ? bvalid : rvalid) !== 1'h1);
      rd = rdata;
      r = wr ? bresp : rresp;
      bready <= 1'h0;
      rready <= 1'h0;
   endtask : bus

   task automatic rd_chk(input logic [A_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
      bus(1'h0, a, ZERO32, q, resp);
      `CHK(q, e)
      `CHK(resp, er)
   endtask : rd_chk

   task automatic wr_chk(input logic [A_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
      bus(1'h1, a, d, q, resp);
      `CHK(resp, er)
   endtask : wr_chk

   // Channels expected on for a counter value, plain or bit reversed
   function automatic logic [NCH-1:0] exp_on(input logic [15:0] k, input logic spread);
      logic [15:0] c;
      c = k;
      if (spread) c = {<<{k}};
      for (int i = 0; i < NCH; i++) exp_on[i] = c < gs[i];
   endfunction : exp_on

   task automatic end_of_test();
      $display("Counts: %0d compares, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test

   // ********************************
   // Scenarios
   // ********************************
   task automatic t_regs();
      rd_chk(A_CTRL, ZERO32, RESP_OK);
      rd_chk(A_STAT, ZERO32, RESP_OK);
      rd_chk(5'h14, ZERO32, RESP_ERR);
      wr_chk(5'h1C, 32'hFFFF_FFFF, RESP_ERR);
      wr_chk(A_IEN, 32'h0000_0007, RESP_OK);
      rd_chk(A_IEN, 32'h0000_0007, RESP_OK);
      wstrb <= 4'hE;
      wr_chk(A_IEN, ZERO32, RESP_OK);
      wstrb <= 4'hF;
      rd_chk(A_IEN, 32'h0000_0007, RESP_OK);
      rd_chk(A_ICLR, ZERO32, RESP_OK);
      `CHK(irq, 1'h0)
      $display("Test regs finished");
   endtask : t_regs

   task automatic t_alarm();
      open_det <= 24'h00_0010;
      settle(8);
      `CHK(alarm_oe, 1'h1)
      `CHK(alarm, 1'h0)
      `CHK(irq, 1'h1)
      blank <= 1'h1;
      settle(8);
      `CHK(alarm_oe, 1'h0)
      hot <= 1'h1;
      settle(8);
      `CHK(alarm_oe, 1'h1)
      rd_chk(A_STAT, 32'h0000_0003, RESP_OK);
      blank <= 1'h0;
      open_det <= '0;
      settle(8);
      `CHK(alarm_oe, 1'h0)
      hot <= 1'h0;
      wr_chk(A_ICLR, 32'h0000_0003, RESP_OK);
      wr_chk(A_IEN, ZERO32, RESP_OK);
      rd_chk(A_STAT, ZERO32, RESP_OK);
      `CHK(irq, 1'h0)
      $display("Test alarm finished");
   endtask : t_alarm

   task automatic t_gray();
      for (int i = 0; i < NCH; i++) gs[i] = 16'(i);
      gs[NCH-1] = 16'h8003;
      for (int i = 0; i < NCH; i++) v[GS_W*i +: GS_W] = gs[i];
      dly <= 1'h1;
      settle(4);
      for (int j = 0; j < 2*SR_W - 1; j++) ctl.send_bit(v[SR_W - 1 - (j % SR_W)]);
      fork
         ctl.send_bit(v[0]);
         begin
            settle(10);
            @(negedge clk);
            `CHK(so, v[0])
         end
      join
      settle(6);
      ctl.end_frame();
      `CHK(so, v[SR_W-1])
      `CHK(sck_rep, 1'h1)
      `CHK(pck_rep, 1'h1)
      ctl.strobe(1'h1);
      ctl.count_edge(1'h1);
      settle(4);
      `CHK(lat_rep, 1'h1)
      bus(1'h0, A_STATE, ZERO32, q, resp);
      `CHK(q[31:16], CNT_FULL)
      `CHK(q[1], 1'h1)
      ctl.count_edge(1'h0);
      ctl.strobe(1'h0);
      settle(8);
      rd_chk(A_STAT, 32'h0000_0004, RESP_OK);
      wr_chk(A_IEN, 32'h0000_0004, RESP_OK);
      settle(2);
      `CHK(irq, 1'h1)
      wr_chk(A_IEN, ZERO32, RESP_OK);
      settle(2);
      `CHK(irq, 1'h0)
      wr_chk(A_ICLR, 32'h0000_0004, RESP_OK);
      rd_chk(A_STAT, ZERO32, RESP_OK);
      for (int j = 0; j < GS_W; j++) ctl.send_bit(1'h1);
      ctl.end_frame();
      for (int k = 0; k < 6; k++) begin
         wave <= (k < 4);
         onep <= (k == 1);
         ctl.count_edge(1'h1);
         settle(2);
         `CHK(chan, exp_on(16'(k), k >= 4))
         bus(1'h0, A_STATE, ZERO32, q, resp);
         `CHK(q[31:16], 16'(k))
         if (k == 2) begin
            blank <= 1'h1;
            settle(6);
            `CHK(chan, '0)
            blank <= 1'h0;
         end
         ctl.count_edge(1'h0);
      end
      $display("Test grayscale finished");
   endtask : t_gray

   task automatic t_corr();
      ph <= 1'h1;
      load_mode_select <= 1'h1;
      dly <= 1'h0;
      settle(6);
      v = '0;
      v[DG_LEN-1 -: GB_W] = 8'h5A;
      for (int i = 0; i < NCH; i++) v[DC_W*i +: DC_W] = 7'(i + 9);
      for (int j = 0; j < DG_LEN - 1; j++) ctl.send_bit(v[DG_LEN-1-j]);
      fork
         ctl.send_bit(v[0]);
         begin
            settle(10);
            @(negedge clk);
            `CHK(so, v[DG_LEN-1])
         end
      join
      settle(6);
      ctl.end_frame();
      `CHK(sck_rep, 1'h0)
      `CHK(pck_rep, 1'h0)
      ctl.strobe(1'h1);
      settle(8);
      ctl.strobe(1'h0);
      settle(8);
      `CHK(gb, v[DG_LEN-1 -: GB_W])
      `CHK(corr, v[NCH*DC_W-1:0])
      ctl.count_edge(1'h1);
      settle(2);
      bus(1'h0, A_STATE, ZERO32, q, resp);
      `CHK(q[31:16], 16'h0000)
      `CHK(q[2], 1'h1)
      `CHK(chan, exp_on(16'h0000, 1'h1))
      ctl.count_edge(1'h0);
      $display("Test correction finished");
   endtask : t_corr

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      settle(2);
      t_regs();
      t_alarm();
      t_gray();
      t_corr();
      end_of_test();
   end

   // Watchdog well beyond the expected run of about eight thousand cycles
   initial begin
      #1_000_000;
      mismatches++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      end_of_test();
   end
endmodule : test_led_grayscale_pwm_serial_driver
